/* File: wdt_pkg.sv */
`default_nettype none
package wdt_pkg;
    // ************************************************************
    // register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] IDX_ENABLE = 8'h37;
    localparam logic [7:0] IDX_ACTION = 8'h38;
    localparam logic [7:0] IDX_COUNT_LO = 8'h39;
    localparam logic [7:0] IDX_COUNT_MID = 8'h3a;
    localparam logic [7:0] IDX_COUNT_HI = 8'h3b;
    localparam logic [7:0] IDX_STATUS = 8'h3c;
    localparam logic [7:0] IDX_INT_STATUS = 8'h3d;
    localparam logic [7:0] IDX_INT_MASK = 8'h3e;

    // ************************************************************
    // field positions, codes and reset values
    // ************************************************************
    localparam int ENABLE_BIT = 6;
    localparam int ACTION_LSB = 4;
    localparam int EXPIRED_BIT = 7;
    localparam int RESTART_BIT = 6;
    localparam int EVT_EXPIRE = 0;
    localparam int EVT_RESTART = 1;
    localparam int COUNT_W = 24;
    localparam int IRQ_W = 16;
    localparam logic [3:0] ACT_NONE = 4'h0;
    localparam logic [3:0] ACT_NMI = 4'hc;
    localparam logic [3:0] ACT_RESET = 4'hd;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h00_0000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 24'h00_0001;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int REF_HZ = 32768;
    localparam int MAX_TIMEOUT_S = 512;
    localparam int PULSE_NS = 1000;
    localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_W = 5;
endpackage : wdt_pkg
`default_nettype wire

/* File: wdt_refsync.sv */
`default_nettype none
module wdt_refsync (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ref_clk_pin,
    output logic ref_tick
);
    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic next_tick;

    // ************************************************************
    // rising edge of the slow reference, seen in the bus clock
    // ************************************************************
    // only sync_b and sync_c are compared; sync_a feeds sync_b alone
    always_comb begin
        next_tick = sync_b & ~sync_c;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
            ref_tick <= 1'b0;
        end else begin
            sync_a <= ref_clk_pin;
            sync_b <= sync_a;
            sync_c <= sync_b;
            ref_tick <= next_tick;
        end
    end
endmodule : wdt_refsync
`default_nettype wire

/* File: wdt_core.sv */
`default_nettype none
module wdt_core
    import wdt_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic ref_clk_pin,
    output logic sys_reset_req,
    output logic nmi_req,
    output logic [IRQ_W-1:0] irq_req,
    output logic irq
);
    typedef enum logic {WDT_BUS_ADDR, WDT_BUS_DATA} wdt_bus_t;

    // ************************************************************
    // helpers
    // ************************************************************
    // action code to irq line, one-hot by line number
    function automatic logic [IRQ_W-1:0] wdt_irq_line(input logic [3:0] code);
        logic [IRQ_W-1:0] line;
        line = 16'h0000;
        case (code)
            4'h1: line[3] = 1'b1;
            4'h2: line[4] = 1'b1;
            4'h3: line[5] = 1'b1;
            4'h4: line[6] = 1'b1;
            4'h5: line[7] = 1'b1;
            4'h6: line[9] = 1'b1;
            4'h7: line[10] = 1'b1;
            4'h8: line[11] = 1'b1;
            4'h9: line[12] = 1'b1;
            4'ha: line[14] = 1'b1;
            4'hb: line[15] = 1'b1;
            default: line = 16'h0000;
        endcase
        return line;
    endfunction : wdt_irq_line

    function automatic logic [7:0] wdt_index(input logic [31:0] addr);
        return addr[9:2];
    endfunction : wdt_index

    // ************************************************************
    // state
    // ************************************************************
    wdt_bus_t bus_state;
    wdt_bus_t next_bus_state;
    logic [7:0] bus_index;
    logic [7:0] next_bus_index;
    logic bus_write;
    logic next_bus_write;
    logic next_hreadyout;
    logic [31:0] next_hrdata;

    logic [7:0] enable_reg;
    logic [7:0] next_enable_reg;
    logic [7:0] action_reg;
    logic [7:0] next_action_reg;
    logic [COUNT_W-1:0] reload;
    logic [COUNT_W-1:0] next_reload;
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] next_count;
    logic [7:0] status_reg;
    logic [7:0] next_status_reg;
    logic [7:0] int_status;
    logic [7:0] next_int_status;
    logic [7:0] int_mask;
    logic [7:0] next_int_mask;
    logic [3:0] fired_code;
    logic [3:0] next_fired_code;
    logic [PULSE_W-1:0] pulse_cnt;
    logic [PULSE_W-1:0] next_pulse_cnt;
    logic next_sys_reset_req;
    logic next_nmi_req;
    logic [IRQ_W-1:0] next_irq_req;
    logic next_irq;

    logic ref_tick;
    logic wr_strobe;
    logic rd_strobe;
    logic restart;
    logic expire;
    logic [7:0] wbyte;

    // ************************************************************
    // reference clock synchroniser
    // ************************************************************
    wdt_refsync wdt_refsync_i (
        .hclk(hclk),
        .hresetn(hresetn),
        .ref_clk_pin(ref_clk_pin),
        .ref_tick(ref_tick)
    );

    // ************************************************************
    // ahb-lite slave: one wait state on every transfer
    // ************************************************************
    // the wait state lets a read straight after a write see the new value
    always_comb begin
        next_bus_state = bus_state;
        next_bus_index = bus_index;
        next_bus_write = bus_write;
        next_hreadyout = 1'b1;
        next_hrdata = hrdata;
        rd_strobe = 1'b0;
        wr_strobe = 1'b0;
        case (bus_state)
            WDT_BUS_ADDR: begin
                if (hsel && htrans[1] && hready) begin
                    next_bus_index = wdt_index(haddr);
                    next_bus_write = hwrite;
                    next_hreadyout = 1'b0;
                    next_bus_state = WDT_BUS_DATA;
                end
            end
            WDT_BUS_DATA: begin
                wr_strobe = bus_write;
                rd_strobe = ~bus_write;
                next_bus_state = WDT_BUS_ADDR;
                if (!bus_write) begin
                    next_hrdata = 32'h0000_0000; // unmapped reads as zero
                    case (bus_index)
                        IDX_ENABLE: next_hrdata[7:0] = enable_reg;
                        IDX_ACTION: next_hrdata[7:0] = action_reg;
                        IDX_COUNT_LO: next_hrdata[7:0] = count[7:0];
                        IDX_COUNT_MID: next_hrdata[7:0] = count[15:8];
                        IDX_COUNT_HI: next_hrdata[7:0] = count[23:16];
                        IDX_STATUS: next_hrdata[7:0] = status_reg;
                        IDX_INT_STATUS: next_hrdata[7:0] = int_status;
                        IDX_INT_MASK: next_hrdata[7:0] = int_mask;
                        default: next_hrdata = 32'h0000_0000;
                    endcase
                end
            end
            default: next_bus_state = WDT_BUS_ADDR;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= WDT_BUS_ADDR;
            bus_index <= REG_RESET;
            bus_write <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            bus_state <= next_bus_state;
            bus_index <= next_bus_index;
            bus_write <= next_bus_write;
            hreadyout <= next_hreadyout;
            hresp <= 1'b0; // always okay
            hrdata <= next_hrdata;
        end
    end

    // ************************************************************
    // registers, counter and expiry
    // ************************************************************
    assign wbyte = hwdata[7:0];
    assign restart = wr_strobe && (bus_index == IDX_STATUS) && wbyte[RESTART_BIT];
    assign expire = enable_reg[ENABLE_BIT] && ref_tick && (count <= COUNT_ONE) && !restart;

    always_comb begin
        next_enable_reg = enable_reg;
        next_action_reg = action_reg;
        next_reload = reload;
        next_count = count;
        next_status_reg = status_reg;
        next_fired_code = fired_code;
        next_pulse_cnt = pulse_cnt;
        if (wr_strobe) begin
            case (bus_index)
                IDX_ENABLE: begin
                    next_enable_reg = wbyte;
                    if (wbyte[ENABLE_BIT] && !enable_reg[ENABLE_BIT]) begin
                        next_count = reload;
                    end
                end
                IDX_ACTION: next_action_reg = wbyte;
                IDX_COUNT_LO: begin
                    next_reload[7:0] = wbyte;
                    next_count[7:0] = wbyte;
                end
                IDX_COUNT_MID: begin
                    next_reload[15:8] = wbyte;
                    next_count[15:8] = wbyte;
                end
                IDX_COUNT_HI: begin
                    next_reload[23:16] = wbyte;
                    next_count[23:16] = wbyte;
                end
                IDX_STATUS: begin
                    // bit 7 is read-only; writing zero to bit 6 does nothing
                    next_status_reg[5:0] = wbyte[5:0];
                    if (wbyte[RESTART_BIT]) begin
                        next_count = reload;
                    end
                end
                default: next_status_reg = next_status_reg;
            endcase
        end
        if (restart) begin
            next_status_reg[EXPIRED_BIT] = 1'b0;
        end
        // one decrement per reference period; full range is 512 s
        if (expire) begin
            next_count = reload;
            next_status_reg[EXPIRED_BIT] = 1'b1;
            next_fired_code = action_reg[7:ACTION_LSB];
            next_pulse_cnt = PULSE_W'(PULSE_CYCLES);
        end else if (enable_reg[ENABLE_BIT] && ref_tick && !restart) begin
            next_count = count - COUNT_ONE;
        end
        if (!expire && pulse_cnt != '0) begin
            next_pulse_cnt = pulse_cnt - PULSE_W'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_reg <= REG_RESET;
            action_reg <= REG_RESET;
            reload <= COUNT_RESET;
            count <= COUNT_RESET;
            status_reg <= REG_RESET;
            fired_code <= ACT_NONE;
            pulse_cnt <= '0;
        end else begin
            enable_reg <= next_enable_reg;
            action_reg <= next_action_reg;
            reload <= next_reload;
            count <= next_count;
            status_reg <= next_status_reg;
            fired_code <= next_fired_code;
            pulse_cnt <= next_pulse_cnt;
        end
    end

    // ************************************************************
    // expiry outputs: a fixed-width pulse on the chosen line only
    // ************************************************************
    // a pulse, not a level, so a periodic irq gives one edge per interval
    always_comb begin
        next_sys_reset_req = (pulse_cnt != '0) && (fired_code == ACT_RESET);
        next_nmi_req = (pulse_cnt != '0) && (fired_code == ACT_NMI);
        next_irq_req = (pulse_cnt != '0) ? wdt_irq_line(fired_code) : 16'h0000;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_reset_req <= 1'b0;
            nmi_req <= 1'b0;
            irq_req <= 16'h0000;
        end else begin
            sys_reset_req <= next_sys_reset_req;
            nmi_req <= next_nmi_req;
            irq_req <= next_irq_req;
        end
    end

    // ************************************************************
    // interrupt status and mask
    // ************************************************************
    // a new event in the clearing read's cycle survives the clear
    always_comb begin
        next_int_status = int_status;
        next_int_mask = int_mask;
        if (rd_strobe && bus_index == IDX_INT_STATUS) begin
            next_int_status = 8'h00;
        end
        if (wr_strobe && bus_index == IDX_INT_MASK) begin
            next_int_mask = wbyte;
        end
        if (expire) begin
            next_int_status[EVT_EXPIRE] = 1'b1;
        end
        if (restart) begin
            next_int_status[EVT_RESTART] = 1'b1;
        end
        next_irq = |(next_int_status & next_int_mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_status <= REG_RESET;
            int_mask <= REG_RESET;
            irq <= 1'b0;
        end else begin
            int_status <= next_int_status;
            int_mask <= next_int_mask;
            irq <= next_irq;
        end
    end

    // hsize is accepted but unused: every access acts on the low byte
    logic unused_hsize;
    assign unused_hsize = ^hsize;
endmodule : wdt_core
`default_nettype wire

/* File: wdt_ref_model.sv */
`default_nettype none
// ****************************************
// free-running reference oscillator
// ****************************************
module wdt_ref_model (
    output logic ref_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    // half of one 30.5 us reference period
    parameter realtime HALF_NS = 15258.789;
    // odd start offset keeps it unrelated in phase to hclk
    initial begin
        ref_clk = 1'b0;
        #7.3;
        forever #(HALF_NS) ref_clk = ~ref_clk;
    end
endmodule : wdt_ref_model
`default_nettype wire

/* File: wdt_core_props.sv */
`default_nettype none
module wdt_core_props
    import wdt_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic sys_reset_req,
    input wire logic nmi_req,
    input wire logic [IRQ_W-1:0] irq_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ****************************************
    // helper: cycles the current pulse has stood
    // ****************************************
    logic out_any;
    logic [7:0] hi_cnt;
    logic [7:0] next_hi_cnt;
    assign out_any = sys_reset_req | nmi_req | (|irq_req);
    always_comb begin
        next_hi_cnt = out_any ? hi_cnt + 8'h01 : 8'h00;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hi_cnt <= 8'h00;
        end else begin
            hi_cnt <= next_hi_cnt;
        end
    end
    // ****************************************
    // bus and consequence properties
    // ****************************************
    sequence taken_s;
        hsel && htrans[1] && hready;
    endsequence
    sequence answer_s;
        !hreadyout ##1 hreadyout;
    endsequence
    bus_answer_a: assert property (taken_s |=> answer_s)
        else $error("bus answer timing wrong");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("error response seen");
    rdata_upper_a: assert property (hrdata[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
    rdata_load_a: assert property ($changed(hrdata) |-> !$past(hreadyout))
        else $error("read data changed outside a read");
    one_cons_a: assert property ($onehot0({sys_reset_req, nmi_req, irq_req}))
        else $error("more than one consequence active");
    irq_lines_a: assert property ((irq_req & 16'h2107) == 16'h0000)
        else $error("unsupported interrupt line driven");
    pulse_len_a: assert property ($fell(out_any) |-> hi_cnt == 8'h19)
        else $error("pulse length wrong");
    pulse_max_a: assert property (out_any |-> hi_cnt < 8'h19)
        else $error("pulse too long");
    pulse_steady_a: assert property (out_any && $past(out_any) |->
        $stable({sys_reset_req, nmi_req, irq_req}))
        else $error("pulse target changed");
endmodule : wdt_core_props
bind wdt_core wdt_core_props wdt_core_props_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sys_reset_req(sys_reset_req), .nmi_req(nmi_req), .irq_req(irq_req));
`default_nettype wire

/* File: test_watchdog_timer.sv */
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("FAIL %0t got %h exp %h", $time, g, e); end end
module test_watchdog_timer
    import wdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp, ref_clk, sys_reset_req, nmi_req, irq;
    logic [31:0] hrdata;
    logic [IRQ_W-1:0] irq_req;
    logic [7:0] r;
    logic [7:0] r0;
    logic [17:0] got, exp_v;
    int num_errors = 0;
    int num_checks = 0;
    int line_of[12] = '{0, 3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};
    always #20 hclk = ~hclk;
    wdt_core wdt_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ref_clk_pin(ref_clk), .sys_reset_req(sys_reset_req), .nmi_req(nmi_req),
        .irq_req(irq_req), .irq(irq));
    wdt_ref_model wdt_ref_model_i (.ref_clk(ref_clk));
    // ****************************************
    // closing report and bus tasks
    // ****************************************
    task automatic end_of_test();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    // one single transfer, address then data phase
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {22'h00_0000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, wd};
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        r = hrdata[7:0];
        if (n >= 50) begin
            num_errors++;
            end_of_test();
        end
    endtask : xfer
    // bounded wait for any consequence pulse
    task automatic wait_out(input int n);
        got = 18'h0_0000;
        for (int i = 0; i < n && got == 18'h0_0000; i++) begin
            @(posedge hclk);
            got = {sys_reset_req, nmi_req, irq_req};
        end
    endtask : wait_out
    task automatic load(input logic [7:0] lo);
        xfer(1'b1, IDX_COUNT_LO, lo);
        xfer(1'b1, IDX_COUNT_MID, 8'h00);
        xfer(1'b1, IDX_COUNT_HI, 8'h00);
        xfer(1'b1, IDX_STATUS, 8'h40);
        xfer(1'b0, IDX_INT_STATUS, 8'h00);
    endtask : load
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b1, 8'h10, 8'hff);
        for (int i = 0; i < 9; i++) begin
            xfer(1'b0, (i == 8) ? 8'h10 : IDX_ENABLE + 8'(i), 8'h00);
            `CHK(r, REG_RESET)
        end
        // byte order of the count, full-scale high byte
        xfer(1'b1, IDX_COUNT_LO, 8'h21);
        xfer(1'b1, IDX_COUNT_MID, 8'h43);
        xfer(1'b1, IDX_COUNT_HI, 8'hff);
        xfer(1'b0, IDX_COUNT_LO, 8'h00);
        `CHK(r, 8'h21)
        xfer(1'b0, IDX_COUNT_MID, 8'h00);
        `CHK(r, 8'h43)
        xfer(1'b0, IDX_COUNT_HI, 8'h00);
        `CHK(r, 8'hff)
        xfer(1'b1, IDX_ENABLE, 8'hbf);
        xfer(1'b0, IDX_ENABLE, 8'h00);
        `CHK(r, 8'hbf)
        // live count: 1003 cycles span one or two reference periods
        xfer(1'b1, IDX_ENABLE, 8'h40);
        xfer(1'b0, IDX_COUNT_LO, 8'h00);
        r0 = r;
        repeat (1000) @(posedge hclk);
        xfer(1'b0, IDX_COUNT_LO, 8'h00);
        `CHK((r0 - r - 8'h01) < 8'h02, 1'b1)
        xfer(1'b1, IDX_ENABLE, 8'h3f);
        // every action code, expiry after two ticks
        for (int c = 0; c < 16; c++) begin
            exp_v = (c >= 1 && c <= 11) ? 18'h0_0001 << line_of[c] :
                (c == 12) ? 18'h1_0000 : (c == 13) ? 18'h2_0000 : 18'h0_0000;
            xfer(1'b1, IDX_INT_MASK, {7'h00, c[0]});
            load(8'h02);
            xfer(1'b1, IDX_ACTION, {c[3:0], 4'h5});
            xfer(1'b1, IDX_ENABLE, 8'h7f);
            wait_out(2500);
            `CHK(got, exp_v)
            if (c == 1) begin
                repeat (40) @(posedge hclk);
                wait_out(2500);
                `CHK(got, exp_v)
            end
            xfer(1'b0, IDX_STATUS, 8'h00);
            `CHK(r[EXPIRED_BIT], 1'b1)
            `CHK(irq, c[0])
            // stop first, so no later expiry lands between the clear and the check
            xfer(1'b1, IDX_ENABLE, 8'h3f);
            xfer(1'b0, IDX_INT_STATUS, 8'h00);
            `CHK(r[EVT_EXPIRE], 1'b1)
            repeat (2) @(posedge hclk);
            `CHK(irq, 1'b0)
        end
        // restarts keep the timer from expiring
        load(8'h03);
        xfer(1'b1, IDX_ACTION, 8'hc0);
        xfer(1'b1, IDX_ENABLE, 8'h40);
        repeat (5) begin
            wait_out(1000);
            `CHK(got, 18'h0_0000)
            xfer(1'b1, IDX_STATUS, 8'h40);
        end
        xfer(1'b0, IDX_STATUS, 8'h00);
        `CHK(r[EXPIRED_BIT], 1'b0)
        xfer(1'b0, IDX_INT_STATUS, 8'h00);
        `CHK(r[EVT_RESTART], 1'b1)
        wait_out(2600);
        `CHK(got, 18'h1_0000)
        xfer(1'b1, IDX_ENABLE, 8'h00);
        repeat (40) @(posedge hclk);
        wait_out(3000);
        `CHK(got, 18'h0_0000)
        end_of_test();
    end
endmodule : test_watchdog_timer
`default_nettype wire
